// [core/rx_err_pkg.sv]
// Constants and types shared by the receive error reporting block
package rx_err_pkg;

  localparam logic [11:0] OFS_MAX_LEN  = 12'h0506;
  localparam logic [11:0] OFS_MAC_CTRL = 12'h050A;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h0510;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h0511;

  localparam logic [31:0] RST_MAX_LEN  = 32'h0000_05EE;
  localparam logic        RST_LEN_CHK  = 1'b0;
  localparam logic [4:0]  RST_MASK     = 5'h00;

  localparam int ERR_MALF  = 0;
  localparam int ERR_CRC   = 1;
  localparam int ERR_UNDER = 2;
  localparam int ERR_OVER  = 3;
  localparam int ERR_LEN   = 4;
  localparam int ERR_RSVD  = 5;

  localparam logic [15:0] MIN_FRAME    = 16'h0009;
  localparam logic [15:0] MIN_GOOD     = 16'h0040;
  localparam logic [15:0] LEN_TYPE_LIM = 16'h0600;
  localparam logic [15:0] HDR_FCS      = 16'h0012;
  localparam logic [15:0] MIN_PAYLOAD  = 16'h002E;
  localparam logic [15:0] LENF_HI      = 16'h000C;
  localparam logic [15:0] LENF_LO      = 16'h000D;

  localparam logic [7:0]  CHAR_START   = 8'hFB;
  localparam logic [7:0]  CHAR_TERM    = 8'hFD;

  localparam logic [31:0] CRC_INIT     = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY     = 32'hEDB8_8320;
  localparam logic [31:0] CRC_RESIDUE  = 32'hDEBB_20E3;

  typedef struct packed {
    logic         valid;
    logic [127:0] d;
    logic [15:0]  c;
  } xl_in_t;

  typedef struct packed {
    logic         valid;
    logic [127:0] d;
    logic [15:0]  c;
    logic [1:0]   sop;
    logic [1:0]   eop;
    logic [5:0]   eop_empty;
    logic [1:0]   idle;
    logic [5:0]   error;
    logic         fcs_error;
    logic         fcs_valid;
  } rx_out_t;

  typedef struct packed {
    logic        in_frame;
    logic [15:0] cnt;
    logic [31:0] crc;
    logic        malf;
    logic [15:0] lenf;
    rx_out_t     stg;
    rx_out_t     out;
    logic        lag_err;
    logic        lag_vld;
    logic [31:0] max_len;
    logic        len_chk;
    logic [4:0]  stat;
    logic [4:0]  mask;
    logic [31:0] rdata;
  } rx_state_t;

endpackage

// [core/rx_frame_err.sv]
// Receive frame status: idle, end of packet, error vector and FCS flags
//
// Behaviour
// - Per-word flag for idle or control words
// - Error vector meaningful only in end cycles
// - Bit 0: stray control character in frame, or frame under nine bytes
// - Bit 1: CRC error, equals FCS flag aligned
// - Bit 2: frame of nine to 63 bytes
// - Bit 3: length above programmed maximum
// - Bit 4: length field mismatch, when enabled
// - FCS error flagged with end of packet
// - Runts force CRC error, short ones not
// - FCS valid strobe marks meaningful FCS flag
// - One-hot end flag on last CRC word
// - Empty count per end word, else zero
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module rx_frame_err
  import rx_err_pkg::*;
#(
  parameter bit ALIGN_EOP_FCS = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire xl_in_t      in_s,
  output var rx_out_t      out,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             irq
);

  localparam rx_state_t ST_RST = '{
    max_len: RST_MAX_LEN,
    len_chk: RST_LEN_CHK,
    mask:    RST_MASK,
    default: '0
  };

  rx_state_t st_q;
  rx_state_t st_d;

  // Bitwise reflected CRC-32, one byte per call
  function automatic logic [31:0] crc_byte(
    input logic [31:0] c,
    input logic [7:0]  b
  );
    logic [31:0] r;
    r = c ^ {24'h0000_00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Byte count includes header and FCS, excludes preamble
  function automatic logic [5:0] frame_err(
    input logic [15:0] n,
    input logic [31:0] crc,
    input logic        malf,
    input logic [15:0] lf,
    input logic [31:0] mx,
    input logic        chk
  );
    logic        short_f;
    logic [15:0] pay;
    logic [5:0]  e;
    short_f = n < MIN_FRAME;
    pay = (n > HDR_FCS) ? 16'(n - HDR_FCS) : 16'h0000;
    e = '0;
    // Too short to be a frame: decoding error only
    e[ERR_MALF] = malf | short_f;
    e[ERR_UNDER] = !short_f && (n < MIN_GOOD);
    e[ERR_CRC] = !short_f &&
                 ((crc != CRC_RESIDUE) || e[ERR_UNDER]);
    e[ERR_OVER] = {16'h0000, n} > mx;
    // Padding to the minimum payload is not a mismatch
    e[ERR_LEN] = chk && !short_f && (lf < LEN_TYPE_LIM) &&
                 ((lf > pay) ||
                  ((pay > MIN_PAYLOAD) && (pay != lf)));
    e[ERR_RSVD] = 1'b0;
    return e;
  endfunction

  always_comb begin
    logic [7:0]  bt;
    logic        fin;
    logic        at0;
    logic [3:0]  last;
    logic [1:0]  pre;
    logic [1:0]  dat;
    logic [1:0]  sop;
    logic [5:0]  err;
    logic        f_err;
    logic        f_vld;
    logic [4:0]  clr;
    st_d  = st_q;
    bt    = '0;
    fin   = 1'b0;
    at0   = 1'b0;
    last  = '0;
    pre   = '0;
    dat   = '0;
    sop   = '0;
    err   = '0;
    f_err = 1'b0;
    f_vld = 1'b0;
    clr   = '0;

    if (in_s.valid) begin
      for (int i = 0; i < 16; i++) begin
        bt = in_s.d[8*i +: 8];
        if (!st_d.in_frame) begin
          // Start only at byte 0 of a word; its word is preamble
          if (in_s.c[i] && bt == CHAR_START && (i % 8) == 0) begin
            st_d.in_frame = 1'b1;
            st_d.cnt      = '0;
            st_d.crc      = CRC_INIT;
            st_d.malf     = 1'b0;
            st_d.lenf     = '0;
            pre[i/8]      = 1'b1;
          end
        end else if (!pre[i/8]) begin
          if (in_s.c[i]) begin
            if (bt == CHAR_TERM) begin
              fin           = 1'b1;
              at0           = (i == 0);
              last          = 4'(i) - 4'h1;
              st_d.in_frame = 1'b0;
              err = frame_err(st_d.cnt, st_d.crc, st_d.malf,
                              st_d.lenf, st_q.max_len,
                              st_q.len_chk);
            end else begin
              st_d.malf = 1'b1;
            end
          end else begin
            if (st_d.cnt == '0) begin
              sop[i/8] = 1'b1;
            end
            dat[i/8] = 1'b1;
            st_d.crc = crc_byte(st_d.crc, bt);
            if (st_d.cnt == LENF_HI) begin
              st_d.lenf[15:8] = bt;
            end
            if (st_d.cnt == LENF_LO) begin
              st_d.lenf[7:0] = bt;
            end
            // Saturate so giant frames still read as oversized
            if (st_d.cnt != 16'hFFFF) begin
              st_d.cnt = st_d.cnt + 16'h0001;
            end
          end
        end
      end

      // Two-stage output so a terminate at byte 0 can
      // mark the word already waiting in the stage
      st_d.out = st_q.stg;
      f_err    = st_q.stg.fcs_error;
      f_vld    = st_q.stg.fcs_valid;
      if (fin && at0) begin
        st_d.out.eop[1]         = 1'b1;
        st_d.out.eop_empty[5:3] = 3'h0;
        st_d.out.error          = err;
        f_err                   = err[ERR_CRC];
        f_vld                   = 1'b1;
      end
      if (ALIGN_EOP_FCS) begin
        st_d.out.fcs_error = f_err;
        st_d.out.fcs_valid = f_vld;
      end else begin
        st_d.out.fcs_error = st_q.lag_err;
        st_d.out.fcs_valid = st_q.lag_vld;
        st_d.lag_err       = f_err;
        st_d.lag_vld       = f_vld;
      end

      st_d.stg       = '0;
      st_d.stg.valid = 1'b1;
      st_d.stg.d     = in_s.d;
      st_d.stg.c     = in_s.c;
      st_d.stg.sop   = sop;
      st_d.stg.idle  = ~dat;
      if (fin && !at0) begin
        st_d.stg.eop[last[3]] = 1'b1;
        st_d.stg.eop_empty[3*last[3] +: 3] =
          3'h7 - last[2:0];
        st_d.stg.error     = err;
        st_d.stg.fcs_error = err[ERR_CRC];
        st_d.stg.fcs_valid = 1'b1;
      end
    end else begin
      // Gap in the stream: stage holds, output shows nothing
      st_d.out = '0;
    end

    // Status: a read clears, but an event in the same cycle wins
    if (rd && addr == OFS_IRQ_STAT) begin
      clr = 5'h1F;
    end
    st_d.stat = (st_q.stat & ~clr) | st_d.out.error[4:0];

    if (wr) begin
      unique case (addr)
        OFS_MAX_LEN:  st_d.max_len = wdata;
        OFS_MAC_CTRL: st_d.len_chk = wdata[0];
        OFS_IRQ_MASK: st_d.mask    = wdata[4:0];
        default:      ;
      endcase
    end

    st_d.rdata = '0;
    if (rd) begin
      unique case (addr)
        OFS_MAX_LEN:  st_d.rdata = st_q.max_len;
        OFS_MAC_CTRL: st_d.rdata = {31'h0000_0000, st_q.len_chk};
        OFS_IRQ_STAT: st_d.rdata = {27'h0000_000, st_q.stat};
        OFS_IRQ_MASK: st_d.rdata = {27'h0000_000, st_q.mask};
        default:      st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign out   = st_q.out;
  assign rdata = st_q.rdata;
  assign irq   = |(st_q.stat & st_q.mask);

  a_rsvd_bit_zero: assert property (@(posedge clk) disable iff (!rstn)
    out.error[ERR_RSVD] == 1'b0)
    else $error("reserved error bit set");

  a_err_only_eop: assert property (@(posedge clk) disable iff (!rstn)
    (out.eop == 2'b00) |-> (out.error == 6'h00))
    else $error("error vector outside end cycle");

  a_eop_onehot: assert property (@(posedge clk) disable iff (!rstn)
    $onehot0(out.eop) && (out.eop == 2'b00 || out.valid))
    else $error("end flag not one-hot or not valid");

  a_empty_zero: assert property (@(posedge clk) disable iff (!rstn)
    (!out.eop[0] |-> out.eop_empty[2:0] == 3'h0) and
    (!out.eop[1] |-> out.eop_empty[5:3] == 3'h0))
    else $error("empty count without end flag");

  a_fcs_with_eop: assert property (@(posedge clk) disable iff (!rstn)
    ALIGN_EOP_FCS |-> (out.fcs_valid == (out.eop != 2'b00)))
    else $error("aligned FCS strobe not with end flag");

  a_fcs_matches: assert property (@(posedge clk) disable iff (!rstn)
    ALIGN_EOP_FCS && out.fcs_valid
      |-> out.fcs_error == out.error[ERR_CRC])
    else $error("FCS flag differs from error bit");

  a_fcs_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !out.fcs_valid |-> !out.fcs_error)
    else $error("FCS error without valid strobe");

  a_runt_crc: assert property (@(posedge clk) disable iff (!rstn)
    out.error[ERR_UNDER] |-> out.error[ERR_CRC])
    else $error("runt frame without CRC error");

  a_idle_sop: assert property (@(posedge clk) disable iff (!rstn)
    (out.sop & out.idle) == 2'b00)
    else $error("start word marked idle");

  // A status read in the event cycle may clear it, which is legal
  a_stat_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (out.error[ERR_OVER] |-> st_q.stat[ERR_OVER]) and
    (out.error[ERR_OVER] && !(rd && addr == OFS_IRQ_STAT)
      |=> st_q.stat[ERR_OVER]))
    else $error("oversize event not held in status");

endmodule

`default_nettype wire

// [verif/rx_client_model.sv]
// Client model that samples frame status at end of packet
`timescale 1ns/1ps
`default_nettype none
module rx_client_model
  import rx_err_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rstn,
  input  wire rx_out_t rx,
  output logic [5:0]   err_q,
  output logic [1:0]   eop_q,
  output logic [5:0]   empty_q,
  output logic         fcs_q,
  output logic [1:0]   idle_q,
  output logic         stray_q
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {err_q, eop_q, empty_q, fcs_q, idle_q, stray_q} <= '0;
    end else begin
      if (rx.valid && |rx.eop) begin
        err_q   <= rx.error;
        eop_q   <= rx.eop;
        empty_q <= rx.eop_empty;
      end
      // Flag may lag its end word, so take it whenever it is valid
      if (rx.fcs_valid) begin
        fcs_q <= rx.fcs_error;
      end
      if (rx.valid && |rx.sop) begin
        idle_q <= rx.idle;
      end
      if (!(|rx.eop) && |rx.error) begin
        stray_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Testbench: frames and register accesses for the receive status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); \
  end end
module tb;
  import rx_err_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  xl_in_t      in_s = '0;
  rx_out_t     out;
  rx_out_t     out_lag;
  logic        lag_fcs_q;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic [5:0]  err_q, empty_q;
  logic [1:0]  eop_q, idle_q;
  logic        fcs_q, stray_q;
  logic [4:0]  msk;
  logic [7:0]  sb[$];
  logic        sc[$];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  rx_frame_err #(.ALIGN_EOP_FCS(1'b1)) rx_frame_err_i (.clk(clk),
    .rstn(rstn), .in_s(in_s), .out(out), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  rx_client_model rx_client_model_i (.clk(clk), .rstn(rstn), .rx(out),
    .err_q(err_q), .eop_q(eop_q), .empty_q(empty_q), .fcs_q(fcs_q),
    .idle_q(idle_q), .stray_q(stray_q));
  // Second copy with the FCS flag lagging its end word
  rx_frame_err #(.ALIGN_EOP_FCS(1'b0)) rx_frame_err_lag_i (.clk(clk),
    .rstn(rstn), .in_s(in_s), .out(out_lag), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(), .irq());
  rx_client_model rx_client_model_lag_i (.clk(clk), .rstn(rstn),
    .rx(out_lag), .err_q(), .eop_q(), .empty_q(), .fcs_q(lag_fcs_q),
    .idle_q(), .stray_q());

  task automatic give_verdict;
    $display("mismatches %0d compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run is about two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK("rdata", e, rdata)
  endtask

  function automatic logic [31:0] crc_upd(logic [31:0] c, logic [7:0] b);
    c ^= {24'h00_0000, b};
    repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction

  // Frame of n bytes from DA to FCS, start at byte 0 of a word pair
  task automatic send(int n, logic [15:0] lf, bit bad, int ctl);
    logic [31:0]  c;
    logic [127:0] d;
    logic [15:0]  k;
    logic [7:0]   f[$];
    f = {};
    for (int i = 0; i < n - 4; i++)
      f.push_back(i == 12 ? lf[15:8] : i == 13 ? lf[7:0] : 8'(i));
    c = CRC_INIT;
    foreach (f[i]) c = crc_upd(c, f[i]);
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) f.push_back(c[8*i+:8]);
    sb = {8'hFB, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5};
    sc = {1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    foreach (f[i]) begin
      sb.push_back(i == ctl ? 8'h07 : f[i]);
      sc.push_back(i == ctl);
    end
    sb.push_back(CHAR_TERM); sc.push_back(1'b1);
    while (sb.size() % 16 != 0) begin
      sb.push_back(8'h07); sc.push_back(1'b1);
    end
    // Output moves only on valid input: two idle pairs drain the
    // stage and then the lagging FCS flag
    repeat (32) begin
      sb.push_back(8'h07); sc.push_back(1'b1);
    end
    for (int i = 0; i < sb.size(); i += 16) begin
      for (int j = 0; j < 16; j++) begin
        d[8*j+:8] = sb[i+j];
        k[j] = sc[i+j];
      end
      @(posedge clk);
      in_s <= '{valid: 1'b1, d: d, c: k};
    end
    @(posedge clk);
    in_s <= '0;
    repeat (3) @(posedge clk);
    // Look at outputs away from the launching edge
    @(negedge clk);
  endtask

  task automatic frame(int n, logic [15:0] lf, bit bad, logic [5:0] e);
    int q;
    q = (8 + n - 1) % 16;
    send(n, lf, bad, -1);
    `CHK("error", e, err_q)
    `CHK("eop", q < 8 ? 2'b01 : 2'b10, eop_q)
    `CHK("empty", 6'(7 - q % 8) << (q < 8 ? 0 : 3), empty_q)
    `CHK("fcs", e[1], fcs_q)
    `CHK("fcs lag", e[1], lag_fcs_q)
    `CHK("idle", 2'b01, idle_q)
    `CHK("irq", |(e[4:0] & msk), irq)
    reg_rd(OFS_IRQ_STAT, {27'h0, e[4:0]});
  endtask

  initial begin
    msk = 5'h1F;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(OFS_MAX_LEN, RST_MAX_LEN);
    reg_rd(OFS_MAC_CTRL, 32'h0000_0000);
    reg_rd(12'h0123, 32'h0000_0000);
    reg_wr(OFS_IRQ_MASK, 32'h0000_001F);
    reg_rd(OFS_IRQ_MASK, 32'h0000_001F);
    frame(64, 16'h0800, 1'b0, 6'h00);
    frame(8, 16'h0800, 1'b0, 6'h01);
    frame(64, 16'h0800, 1'b1, 6'h02);
    frame(9, 16'h0800, 1'b0, 6'h06);
    frame(63, 16'h0800, 1'b0, 6'h06);
    reg_wr(OFS_MAX_LEN, 32'h0000_0064);
    frame(100, 16'h0800, 1'b0, 6'h00);
    frame(101, 16'h0800, 1'b0, 6'h08);
    reg_wr(OFS_MAX_LEN, RST_MAX_LEN);
    frame(80, 16'h0028, 1'b0, 6'h00);
    reg_wr(OFS_MAC_CTRL, 32'h0000_0001);
    frame(80, 16'h0028, 1'b0, 6'h10);
    frame(80, 16'h0600, 1'b0, 6'h00);
    msk = 5'h00;
    reg_wr(OFS_IRQ_MASK, 32'h0000_0000);
    frame(64, 16'h0800, 1'b1, 6'h02);
    send(64, 16'h0800, 1'b0, 30);
    `CHK("malformed", 1'b1, err_q[0])
    `CHK("stray", 1'b0, stray_q)
    give_verdict();
  end
endmodule
`default_nettype wire
